// >>> bench/pcihb_host.sv
// Host model: arbiter and target for the device's own cycles
`timescale 1ns/1ps
`default_nettype none
module pcihb_host #(
  parameter logic [31:0] RD_WORD = 32'h5A5A_0FF0
) (
  input  wire logic        clk_in,
  input  wire logic        req_n_in,
  input  wire logic        frame_n_in,
  input  wire logic        mine_in,
  input  wire logic        irdy_n_in,
  input  wire logic [31:0] ad_in,
  input  wire logic [3:0]  cbe_in,
  input  wire logic [1:0]  mode_in,
  output logic             gnt_n_out,
  output logic             devsel_n_out,
  output logic             trdy_n_out,
  output logic             stop_n_out,
  output logic             oe_out,
  output logic      [31:0] ad_out,
  output logic             par_out,
  output logic             par_oe_out,
  output logic      [31:0] wr_out
);
  // Mode 0 prompt, 1 slow, 2 no claim, 3 stop
  logic       act = 1'h0;
  logic       rd;
  logic       frame_q;
  logic [1:0] cnt;
  assign devsel_n_out = !(act && cnt == 2'h0);
  assign trdy_n_out   = devsel_n_out || mode_in == 2'h3;
  assign stop_n_out   = devsel_n_out || mode_in != 2'h3;
  // data only while claimed for a read
  assign oe_out = !devsel_n_out && rd;
  assign ad_out = RD_WORD;
  always @(posedge clk_in)
  begin
    gnt_n_out  <= req_n_in;
    frame_q    <= frame_n_in;
    par_out    <= ^{ad_out, cbe_in};
    par_oe_out <= oe_out;
    if (frame_q && !frame_n_in && mine_in)
    begin
      act <= mode_in != 2'h2;
      rd  <= cbe_in == 4'h6;
      cnt <= {mode_in[0], 1'h0};
    end
    else if (act && cnt != 2'h0)
      cnt <= cnt - 2'h1;
    else if (act && (!stop_n_out || !(irdy_n_in || trdy_n_out)))
    begin
      act    <= 1'h0;
      wr_out <= ad_in;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// Bench: host-side stimulus and checks for the bus interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pcihb_pkg::*;
  localparam logic [31:0] RDW = 32'h5A5A_0FF0;
  logic clk_in, rstn_in, par_in, frame_n_in, irdy_n_in, trdy_n_in, devsel_n_in, stop_n_in, perr_n_in;
  logic clkrun_n_in, gnt_n_in, idsel_in, card_on_in, phy_por_n_in, int_req_in, wake_in, pme_clr_in;
  logic mst_req_in, mst_write_in, ad_oe_out, cbe_oe_out, par_out, par_oe_out, frame_n_out, frame_oe_out;
  logic irdy_n_out, irdy_oe_out, trdy_n_out, trdy_oe_out, devsel_n_out, devsel_oe_out, stop_n_out;
  logic stop_oe_out, perr_n_out, perr_oe_out, serr_n_out, serr_oe_out, clkrun_n_out, clkrun_oe_out;
  logic req_n_out, inta_n_out, inta_oe_out, pme_n_out, pme_oe_out, phy_rst_n_out, mst_busy_out;
  logic mst_done_out, tgt_write_out, par_flag_out, clk_running_out, mode_card_out;
  logic [31:0] ad_in, mst_addr_in, mst_wdata_in, ad_out, mst_rdata_out, tgt_wdata_out;
  logic [31:0] t_ad, p_ad, p_wr, ad_q, w_data, rd;
  logic [3:0]  cbe_in, mst_be_n_in, cbe_out, tgt_addr_out, t_cbe, cbe_q, w_addr;
  logic [1:0]  mst_status_out, p_mode;
  logic t_adoe, t_par, t_paroe, t_frame_n, t_irdy_n, t_stop, tick, p_oe, p_par, p_paroe;
  logic p_trdy_n, p_devsel_n, p_stop_n, oe_q = 1'h0;
  int   err_total = 0, checked = 0, n_perr = 0, n_serr = 0, n_flag = 0, n_clk = 0;
  // Undriven data shows a toggling pattern; parity-error is pulled up, other controls come from the bench or host model
  assign ad_in = ad_oe_out ? ad_out : p_oe ? p_ad : t_adoe ? t_ad : {32{tick}};
  assign cbe_in = cbe_oe_out ? cbe_out : t_cbe;
  assign par_in = par_oe_out ? par_out : p_paroe ? p_par : t_paroe ? t_par : tick;
  assign frame_n_in = frame_oe_out ? frame_n_out : t_frame_n;
  assign irdy_n_in = irdy_oe_out ? irdy_n_out : t_irdy_n;
  assign trdy_n_in = trdy_oe_out ? trdy_n_out : p_trdy_n;
  assign devsel_n_in = devsel_oe_out ? devsel_n_out : p_devsel_n;
  assign stop_n_in = stop_oe_out ? stop_n_out : p_stop_n;
  assign perr_n_in = perr_oe_out ? perr_n_out : 1'h1;
  // Clock-run idles high only while the host has the clock stopped
  assign clkrun_n_in = clkrun_oe_out ? clkrun_n_out : t_stop;
  pcihb_top pcihb_top_inst (.*);
  pcihb_host #(.RD_WORD(RDW)) pcihb_host_inst (.clk_in(clk_in), .req_n_in(req_n_out),
    .frame_n_in(frame_n_in), .mine_in(frame_oe_out), .irdy_n_in(irdy_n_in), .ad_in(ad_in),
    .cbe_in(cbe_in), .mode_in(p_mode), .gnt_n_out(gnt_n_in), .devsel_n_out(p_devsel_n),
    .trdy_n_out(p_trdy_n), .stop_n_out(p_stop_n), .oe_out(p_oe), .ad_out(p_ad), .par_out(p_par),
    .par_oe_out(p_paroe), .wr_out(p_wr));
  task automatic chk(input logic [63:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    clk_in = 1'h0;
    forever #20 clk_in = !clk_in;
  end
  always @(posedge clk_in)
  begin
    tick <= !tick;
    chk(par_oe_out, oe_q);
    if (oe_q && par_oe_out)
      chk(par_out, ^{ad_q, cbe_q});
    {oe_q, ad_q, cbe_q} = {ad_oe_out, ad_in, cbe_in};
    if (tgt_write_out)
      {w_addr, w_data} = {tgt_addr_out, tgt_wdata_out};
    n_perr += perr_oe_out && !perr_n_out;
    n_serr += serr_oe_out;
    n_flag += par_flag_out;
    n_clk += clkrun_oe_out;
  end
  task automatic do_reset(input logic card);
    {card_on_in, rstn_in} = {card, 1'h0};
    repeat (12) @(negedge clk_in);
    rstn_in = 1'h1;
    repeat (6) @(negedge clk_in);
    chk({mode_card_out, req_n_out, ad_oe_out}, {card, 2'h2});
  endtask
  // Host as initiator, one data phase; bad flags spoil parity
  task automatic tgt_cyc(input logic [3:0] cmd, input logic [31:0] addr, data, input logic sel,
                         input logic [1:0] bad, input logic claim);
    int n = 0;
    @(negedge clk_in);
    {t_frame_n, t_adoe, t_ad, t_cbe, idsel_in} = {1'h0, 1'h1, addr, cmd, sel};
    @(negedge clk_in);
    // parity trails address; write data with ready
    {t_par, t_paroe, t_frame_n, t_irdy_n, t_cbe, idsel_in} = {^{addr, cmd} ^ bad[0], 3'h6, 4'h0, 1'h0};
    {t_ad, t_adoe} = {data, cmd[0]};
    while (trdy_n_in && n < 6)
    begin
      @(negedge clk_in);
      n++;
    end
    chk({trdy_n_in, devsel_n_in, stop_n_in}, {3{!claim}});
    rd = ad_in;
    @(negedge clk_in);
    {t_par, t_paroe, t_irdy_n, t_adoe} = {^data ^ bad[1], cmd[0], 2'h2};
    @(negedge clk_in);
    t_paroe = 1'h0;
    repeat (3) @(negedge clk_in);
  endtask
  task automatic mst_cyc(input logic wr, input logic [31:0] data, input logic [1:0] mode, st);
    int n = 0;
    p_mode = mode;
    @(negedge clk_in);
    {mst_req_in, mst_write_in, mst_addr_in, mst_wdata_in} = {1'h1, wr, 32'h2000_0040, data};
    @(negedge clk_in);
    chk(req_n_out, 1'h0);
    chk(mst_busy_out, 1'h1);
    while (!mst_done_out && n < 30)
    begin
      @(negedge clk_in);
      n++;
    end
    chk(mst_status_out, st);
    if (st == MST_OK)
      chk(wr ? p_wr : mst_rdata_out, wr ? data : RDW);
    mst_req_in = 1'h0;
    repeat (4) @(negedge clk_in);
  endtask
  task automatic misc();
    @(negedge clk_in);
    {phy_por_n_in, wake_in, int_req_in} = 3'h3;
    #1;
    chk(phy_rst_n_out, 1'h0);
    @(negedge clk_in);
    chk({inta_oe_out, inta_n_out}, 2'h2);
    {phy_por_n_in, wake_in, int_req_in} = 3'h4;
    @(negedge clk_in);
    chk(phy_rst_n_out, 1'h0);
    repeat (3) @(negedge clk_in);
    chk({phy_rst_n_out, pme_oe_out, pme_n_out, inta_oe_out}, 4'hC);
    pme_clr_in = 1'h1;
    @(negedge clk_in);
    pme_clr_in = 1'h0;
    repeat (3) @(negedge clk_in);
    chk(pme_oe_out, 1'h0);
  endtask
  initial
  begin
    {rstn_in, idsel_in, card_on_in, int_req_in, wake_in, pme_clr_in, mst_req_in, mst_write_in} = 8'h0;
    {phy_por_n_in, t_adoe, t_paroe, t_frame_n, t_irdy_n, t_stop, tick, t_par} = 8'h98;
    {mst_addr_in, mst_wdata_in, t_ad, mst_be_n_in, t_cbe, p_mode} = 106'h0;
    do_reset(1'h0);
    tgt_cyc(CMD_CFG_WR, 32'h0000_0008, 32'hCAFE_0001, 1'h1, 2'h0, 1'h1);
    chk({w_addr, w_data}, {4'h2, 32'hCAFE_0001});
    tgt_cyc(CMD_MEM_WR, MEM_BASE + 32'hC, 32'h3C3C_A5A5, 1'h0, 2'h0, 1'h1);
    tgt_cyc(CMD_MEM_RD, MEM_BASE + 32'hC, 32'h0, 1'h0, 2'h0, 1'h1);
    chk(rd, 32'h3C3C_A5A5);
    tgt_cyc(CMD_MEM_WR, MEM_BASE + 32'h10, 32'h0000_00FF, 1'h0, 2'h2, 1'h1);
    chk({n_perr, n_flag}, {32'h1, 32'h1});
    tgt_cyc(CMD_MEM_RD, 32'h1000_0000, 32'h0, 1'h0, 2'h1, 1'h0);
    chk(n_serr, 1'h1);
    mst_cyc(1'h1, 32'h1111_2222, 2'h0, MST_OK);
    mst_cyc(1'h0, 32'h0, 2'h1, MST_OK);
    chk(n_clk, 1'h0);
    t_stop = 1'h1;
    mst_cyc(1'h0, 32'h0, 2'h2, MST_ABORT);
    chk(n_clk != 0, 1'h1);
    t_stop = 1'h0;
    mst_cyc(1'h1, 32'h0, 2'h3, MST_STOP);
    chk(clk_running_out, 1'h1);
    misc();
    do_reset(1'h1);
    tgt_cyc(CMD_CFG_WR, 32'h0000_0004, 32'h1, 1'h1, 2'h0, 1'h0);
    end_sim();
  end
  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire

// >>> rtl/pcihb_par_if.sv
// Carrier between the bus core and its parity unit
`timescale 1ns/1ps
`default_nettype none
interface pcihb_par_if;
  logic [31:0] ad_drv;
  logic [3:0]  cbe_drv;
  logic        drv;
  logic [31:0] ad_bus;
  logic [3:0]  cbe_bus;
  logic        par_bus;
  logic        par_o;
  logic        par_oe;
  logic        par_err;
  modport core (output ad_drv, cbe_drv, drv, ad_bus, cbe_bus, par_bus, input par_o, par_oe, par_err);
  modport unit (input ad_drv, cbe_drv, drv, ad_bus, cbe_bus, par_bus, output par_o, par_oe, par_err);
endinterface
`default_nettype wire

// >>> rtl/pcihb_parity.sv
// Even parity generation and checking, one clock behind address/data
`timescale 1ns/1ps
`default_nettype none
module pcihb_parity
  import pcihb_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rstn_in,
  pcihb_par_if.unit   par_if
);
  typedef struct packed {
    logic par;
    logic oe;
    logic calc;
  } pcihb_par_s;

  pcihb_par_s par_reg;
  pcihb_par_s par_next;

  always_comb
  begin
    par_next      = par_reg;
    par_next.par  = ^{par_if.ad_drv, par_if.cbe_drv};
    par_next.oe   = par_if.drv;
    par_next.calc = ^{par_if.ad_bus, par_if.cbe_bus};
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      par_reg <= '0;
    else
      par_reg <= par_next;
  end

  assign par_if.par_o   = par_reg.par;
  assign par_if.par_oe  = par_reg.oe;
  // Parity line lags the data it covers by one clock
  assign par_if.par_err = par_if.par_bus ^ par_reg.calc;
endmodule
`default_nettype wire

// >>> rtl/pcihb_pkg.sv
// Shared constants and types for the host bus interface
`default_nettype none
package pcihb_pkg;
  // Bus commands carried on the command/byte-enable lines
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_CFG_RD  = 4'hA;
  localparam logic [3:0] CMD_CFG_WR  = 4'hB;
  // Memory window claimed as target, 64 bytes
  localparam logic [31:0] MEM_BASE   = 32'hF000_0000;
  localparam int          MEM_LSB    = 6;
  localparam int          SPACE_WORDS = 16;
  // Cycles in data phase with no target claim before master abort
  localparam logic [2:0] DEVSEL_TIMEOUT = 3'h4;
  // Cycles the clock-run line is held low per request
  localparam logic [1:0] CLKRUN_HOLD = 2'h2;
  // Cycles after reset release before the mode strap is taken
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic       STRAP_CARDBUS = 1'h1;
  // Master completion status
  localparam logic [1:0] MST_OK    = 2'h0;
  localparam logic [1:0] MST_ABORT = 2'h1;
  localparam logic [1:0] MST_STOP  = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_TDATA = 7'h02,
    ST_TTURN = 7'h04,
    ST_MREQ  = 7'h08,
    ST_MADDR = 7'h10,
    ST_MDATA = 7'h20,
    ST_MTURN = 7'h40
  } pcihb_state_e;
endpackage
`default_nettype wire

// >>> rtl/pcihb_sync.sv
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pcihb_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         arstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcihb_sync_s;

  pcihb_sync_s sync_reg;
  pcihb_sync_s sync_next;

  always_comb
  begin
    sync_next    = sync_reg;
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clk_in or negedge arstn_in)
  begin
    if (!arstn_in)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign q_out = sync_reg.s2;
endmodule
`default_nettype wire

// >>> rtl/pcihb_top.sv
// Host bus interface: target, master, parity and error signalling
//
// Summary of operation
// - Driver of address/data also drives parity, even over data and commands.
// - Parity driven when address/data driven, otherwise taken as input.
// - Initiator asserts frame from cycle start through the burst.
// - Target ready marks that the target can complete the data phase.
// - On writes, initiator ready only while valid data is driven.
// - On reads, initiator ready means ready to take target data.
// - Bus request asserted to the arbiter whenever mastership is needed.
// - Target asserts device select after decoding its own address.
// - Target stop asks the master to end; master then terminates.
// - Clock-run sensed for clock state and driven to request the clock.
// - Data parity errors go on the parity-error line, special cycles excepted.
// - Parity-error driven when receiving data, sampled only when sending write data as master.
// - System error reports address parity and special-cycle data parity errors.
// - Bus interface runs synchronously on the host bus clock.
// - Interrupt requests go out on interrupt line A.
// - Power-management event output asserted on a wake event.
// - Command lines carry command in address phase, byte enables in data.
// - Strap high selects Cardbus mode; configuration select then ignored.
// - Physical layer reset comes from its own power-on reset input.
`timescale 1ns/1ps
`default_nettype none
module pcihb_top
  import pcihb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic [31:0] ad_in,
  output logic      [31:0] ad_out,
  output logic             ad_oe_out,
  input  wire logic [3:0]  cbe_in,
  output logic      [3:0]  cbe_out,
  output logic             cbe_oe_out,
  input  wire logic        par_in,
  output logic             par_out,
  output logic             par_oe_out,
  input  wire logic        frame_n_in,
  output logic             frame_n_out,
  output logic             frame_oe_out,
  input  wire logic        irdy_n_in,
  output logic             irdy_n_out,
  output logic             irdy_oe_out,
  input  wire logic        trdy_n_in,
  output logic             trdy_n_out,
  output logic             trdy_oe_out,
  input  wire logic        devsel_n_in,
  output logic             devsel_n_out,
  output logic             devsel_oe_out,
  input  wire logic        stop_n_in,
  output logic             stop_n_out,
  output logic             stop_oe_out,
  input  wire logic        perr_n_in,
  output logic             perr_n_out,
  output logic             perr_oe_out,
  output logic             serr_n_out,
  output logic             serr_oe_out,
  input  wire logic        clkrun_n_in,
  output logic             clkrun_n_out,
  output logic             clkrun_oe_out,
  output logic             req_n_out,
  input  wire logic        gnt_n_in,
  input  wire logic        idsel_in,
  output logic             inta_n_out,
  output logic             inta_oe_out,
  output logic             pme_n_out,
  output logic             pme_oe_out,
  input  wire logic        card_on_in,
  input  wire logic        phy_por_n_in,
  output logic             phy_rst_n_out,
  input  wire logic        int_req_in,
  input  wire logic        wake_in,
  input  wire logic        pme_clr_in,
  input  wire logic        mst_req_in,
  input  wire logic        mst_write_in,
  input  wire logic [31:0] mst_addr_in,
  input  wire logic [31:0] mst_wdata_in,
  input  wire logic [3:0]  mst_be_n_in,
  output logic             mst_busy_out,
  output logic             mst_done_out,
  output logic [1:0]       mst_status_out,
  output logic [31:0]      mst_rdata_out,
  output logic             tgt_write_out,
  output logic [3:0]       tgt_addr_out,
  output logic [31:0]      tgt_wdata_out,
  output logic             par_flag_out,
  output logic             clk_running_out,
  output logic             mode_card_out
);
  typedef struct packed {
    pcihb_state_e st;
    logic [SPACE_WORDS-1:0][31:0] space;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic        mode_card;
    logic        frame_q;
    logic [3:0]  tidx;
    logic        twr;
    logic        spc;
    logic        chk_data;
    logic        chk_serr;
    logic [31:0] ad_o;
    logic        ad_oe;
    logic [3:0]  cbe_o;
    logic        cbe_oe;
    logic        frame_a;
    logic        frame_oe;
    logic        irdy_a;
    logic        irdy_oe;
    logic        trdy_a;
    logic        devsel_a;
    logic        stop_a;
    logic        tctl_oe;
    logic        perr_a;
    logic        perr_oe;
    logic        serr_a;
    logic        req_a;
    logic [1:0]  crun_cnt;
    logic        clk_run;
    logic [2:0]  tout;
    logic        mwr;
    logic        mdone;
    logic [1:0]  mstat;
    logic [31:0] mrdata;
    logic [1:0]  wchk;
    logic        par_flag;
    logic        tgt_we;
    logic [31:0] tgt_wd;
    logic        inta;
    logic        pme;
  } pcihb_core_s;

  pcihb_core_s core_reg;
  pcihb_core_s core_next;
  logic [1:0]  pin_sync;
  logic        phy_sync;

  pcihb_par_if par_if ();

  // Select only in bus mode
  // Target claim: configuration by select, or the memory window
  function automatic logic dec_hit(input logic [3:0] cmd, input logic [31:0] addr,
                                   input logic sel, input logic card);
    logic cfg;
    logic mem;
    cfg = (cmd == CMD_CFG_RD || cmd == CMD_CFG_WR) && sel && (card != STRAP_CARDBUS) && (addr[1:0] == 2'h0);
    mem = (cmd == CMD_MEM_RD || cmd == CMD_MEM_WR) && (addr[31:MEM_LSB] == MEM_BASE[31:MEM_LSB]);
    return cfg || mem;
  endfunction

  pcihb_sync #(.W(2)) u_pin_sync (
    .clk_in   (clk_in),
    .arstn_in (rstn_in),
    .d_in     ({wake_in, card_on_in}),
    .q_out    (pin_sync)
  );

  pcihb_sync #(.W(1)) u_phy_rst (
    .clk_in   (clk_in),
    .arstn_in (phy_por_n_in),
    .d_in     (1'h1),
    .q_out    (phy_sync)
  );

  pcihb_parity u_parity (
    .clk_in  (clk_in),
    .rstn_in (rstn_in),
    .par_if  (par_if)
  );

  assign par_if.ad_drv  = core_reg.ad_o;
  assign par_if.cbe_drv = core_reg.cbe_oe ? core_reg.cbe_o : cbe_in;
  assign par_if.drv     = core_reg.ad_oe;
  assign par_if.ad_bus  = ad_in;
  assign par_if.cbe_bus = cbe_in;
  assign par_if.par_bus = par_in;

  always_comb
  begin
    core_next           = core_reg;
    core_next.tgt_we    = 1'h0;
    core_next.mdone     = 1'h0;
    core_next.chk_data  = 1'h0;
    core_next.chk_serr  = 1'h0;
    core_next.frame_q   = frame_n_in;
    core_next.clk_run   = ~clkrun_n_in;
    core_next.inta      = int_req_in;
    // Wake sets, set wins over clear
    core_next.pme       = pin_sync[1] | (core_reg.pme & ~pme_clr_in);
    core_next.wchk      = {core_reg.wchk[0], 1'h0};
    if (!core_reg.strap_done)
    begin
      if (core_reg.strap_cnt == STRAP_WAIT)
      begin
        core_next.strap_done = 1'h1;
        core_next.mode_card  = pin_sync[0];
      end
      else
        core_next.strap_cnt = core_reg.strap_cnt + 2'h1;
    end
    if (core_reg.chk_data && par_if.par_err)
    begin
      core_next.perr_a  = 1'h1;
      core_next.perr_oe = 1'h1;
    end
    else if (core_reg.perr_a)
      core_next.perr_a = 1'h0;
    else
      core_next.perr_oe = 1'h0;
    core_next.serr_a   = core_reg.chk_serr && par_if.par_err;
    core_next.par_flag = (core_reg.chk_data && par_if.par_err) || (core_reg.wchk[1] && !perr_n_in);
    if (frame_n_in && irdy_n_in)
      core_next.spc = 1'h0;
    if (core_reg.spc && !irdy_n_in)
      core_next.chk_serr = 1'h1;
    if (core_reg.crun_cnt != 2'h0)
      core_next.crun_cnt = core_reg.crun_cnt - 2'h1;
    else if (clkrun_n_in && (core_reg.st != ST_IDLE || mst_req_in))
      core_next.crun_cnt = CLKRUN_HOLD;
    case (core_reg.st)
      ST_IDLE:
      begin
        if (!frame_n_in && core_reg.frame_q)
        begin
          core_next.chk_serr = 1'h1;
          if (cbe_in == CMD_SPECIAL)
            core_next.spc = 1'h1;
          if (dec_hit(cbe_in, ad_in, idsel_in, core_reg.mode_card))
          begin
            core_next.st       = ST_TDATA;
            core_next.tidx     = ad_in[5:2];
            core_next.twr      = cbe_in[0];
            core_next.devsel_a = 1'h1;
            core_next.trdy_a   = 1'h1;
            core_next.stop_a   = 1'h1;
            core_next.tctl_oe  = 1'h1;
            core_next.ad_o     = core_reg.space[ad_in[5:2]];
            core_next.ad_oe    = ~cbe_in[0];
          end
        end
        else if (mst_req_in)
        begin
          core_next.st    = ST_MREQ;
          core_next.req_a = 1'h1;
        end
      end
      ST_TDATA:
      begin
        if (!irdy_n_in)
        begin
          if (core_reg.twr)
          begin
            for (int b = 0; b < 4; b++)
              if (!cbe_in[b])
                core_next.space[core_reg.tidx][8*b +: 8] = ad_in[8*b +: 8];
            core_next.tgt_we   = 1'h1;
            core_next.tgt_wd   = ad_in;
            core_next.chk_data = 1'h1;
          end
          core_next.st       = ST_TTURN;
          core_next.devsel_a = 1'h0;
          core_next.trdy_a   = 1'h0;
          core_next.stop_a   = 1'h0;
          core_next.ad_oe    = 1'h0;
        end
      end
      ST_TTURN:
      begin
        core_next.tctl_oe = 1'h0;
        core_next.st      = ST_IDLE;
      end
      ST_MREQ:
      begin
        // Start only on grant and idle bus
        if (!gnt_n_in && frame_n_in && irdy_n_in)
        begin
          core_next.st       = ST_MADDR;
          core_next.req_a    = 1'h0;
          core_next.frame_a  = 1'h1;
          core_next.frame_oe = 1'h1;
          core_next.ad_o     = mst_addr_in;
          core_next.ad_oe    = 1'h1;
          core_next.cbe_o    = mst_write_in ? CMD_MEM_WR : CMD_MEM_RD;
          core_next.cbe_oe   = 1'h1;
          core_next.irdy_a   = 1'h0;
          core_next.irdy_oe  = 1'h1;
        end
      end
      ST_MADDR:
      begin
        // Single phase, so frame drops with the data phase
        core_next.st      = ST_MDATA;
        core_next.frame_a = 1'h0;
        core_next.irdy_a  = 1'h1;
        core_next.cbe_o   = mst_be_n_in;
        core_next.ad_o    = mst_wdata_in;
        core_next.ad_oe   = mst_write_in;
        core_next.tout    = 3'h0;
        core_next.mwr     = mst_write_in;
      end
      ST_MDATA:
      begin
        core_next.st = ST_MTURN;
        if (!trdy_n_in && !devsel_n_in)
        begin
          core_next.mstat = MST_OK;
          if (!core_reg.mwr)
          begin
            core_next.mrdata   = ad_in;
            core_next.chk_data = 1'h1;
          end
          else
            core_next.wchk = 2'h3;
        end
        else if (!stop_n_in)
          core_next.mstat = MST_STOP;
        else if (devsel_n_in && core_reg.tout == DEVSEL_TIMEOUT)
          core_next.mstat = MST_ABORT;
        else
        begin
          core_next.st   = ST_MDATA;
          core_next.tout = core_reg.tout + 3'h1;
        end
        if (core_next.st == ST_MTURN)
        begin
          core_next.irdy_a   = 1'h0;
          core_next.frame_oe = 1'h0;
          core_next.ad_oe    = 1'h0;
          core_next.cbe_oe   = 1'h0;
          core_next.mdone    = 1'h1;
        end
      end
      ST_MTURN:
      begin
        core_next.irdy_oe = 1'h0;
        core_next.st      = ST_IDLE;
      end
      default:
        core_next.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      core_reg    <= '0;
      core_reg.st <= ST_IDLE;
    end
    else
      core_reg <= core_next;
  end

  assign ad_out          = core_reg.ad_o;
  assign ad_oe_out       = core_reg.ad_oe;
  assign cbe_out         = core_reg.cbe_o;
  assign cbe_oe_out      = core_reg.cbe_oe;
  assign par_out         = par_if.par_o;
  assign par_oe_out      = par_if.par_oe;
  assign frame_n_out     = ~core_reg.frame_a;
  assign frame_oe_out    = core_reg.frame_oe;
  assign irdy_n_out      = ~core_reg.irdy_a;
  assign irdy_oe_out     = core_reg.irdy_oe;
  assign trdy_n_out      = ~core_reg.trdy_a;
  assign devsel_n_out    = ~core_reg.devsel_a;
  assign stop_n_out      = ~core_reg.stop_a;
  assign trdy_oe_out     = core_reg.tctl_oe;
  assign devsel_oe_out   = core_reg.tctl_oe;
  assign stop_oe_out     = core_reg.tctl_oe;
  assign perr_n_out      = ~core_reg.perr_a;
  assign perr_oe_out     = core_reg.perr_oe;
  // Open-drain lines only ever pull low
  assign serr_n_out      = 1'h0;
  assign serr_oe_out     = core_reg.serr_a;
  assign clkrun_n_out    = 1'h0;
  assign clkrun_oe_out   = core_reg.crun_cnt != 2'h0;
  assign req_n_out       = ~core_reg.req_a;
  assign inta_n_out      = 1'h0;
  assign inta_oe_out     = core_reg.inta;
  assign pme_n_out       = 1'h0;
  assign pme_oe_out      = core_reg.pme;
  assign phy_rst_n_out   = phy_sync;
  assign mst_busy_out    = core_reg.st[3] | core_reg.st[4] | core_reg.st[5] | core_reg.st[6];
  assign mst_done_out    = core_reg.mdone;
  assign mst_status_out  = core_reg.mstat;
  assign mst_rdata_out   = core_reg.mrdata;
  assign tgt_write_out   = core_reg.tgt_we;
  assign tgt_addr_out    = core_reg.tidx;
  assign tgt_wdata_out   = core_reg.tgt_wd;
  assign par_flag_out    = core_reg.par_flag;
  assign clk_running_out = core_reg.clk_run;
  assign mode_card_out   = core_reg.mode_card;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_par_even;
    par_oe_out |-> (par_out == ^{$past(ad_out), $past(cbe_oe_out) ? $past(cbe_out) : $past(cbe_in)});
  endproperty
  a_par_even: assert property (p_par_even) else $error("parity not even");

  property p_par_dir;
    par_oe_out == $past(ad_oe_out);
  endproperty
  a_par_dir: assert property (p_par_dir) else $error("parity drive mismatch");

  property p_frame_start;
    (core_reg.st == ST_MADDR) |-> (frame_oe_out && !frame_n_out) ##1 (frame_oe_out && frame_n_out && !irdy_n_out);
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame sequence wrong");

  property p_trdy_claim;
    (trdy_oe_out && !trdy_n_out) |-> (!devsel_n_out && devsel_oe_out);
  endproperty
  a_trdy_claim: assert property (p_trdy_claim) else $error("ready without select");

  property p_irdy_write;
    (irdy_oe_out && !irdy_n_out && core_reg.mwr) |-> ad_oe_out;
  endproperty
  a_irdy_write: assert property (p_irdy_write) else $error("ready without write data");

  property p_req;
    (core_reg.st == ST_IDLE && mst_req_in && frame_n_in) |=> !req_n_out || !trdy_n_out;
  endproperty
  a_req: assert property (p_req) else $error("request not raised");

  property p_grant;
    $rose(frame_oe_out) |-> !$past(gnt_n_in);
  endproperty
  a_grant: assert property (p_grant) else $error("frame without grant");

  property p_stop_end;
    (core_reg.st == ST_MDATA && !stop_n_in && trdy_n_in) |=> (!frame_oe_out && mst_done_out) ##1 !irdy_oe_out;
  endproperty
  a_stop_end: assert property (p_stop_end) else $error("stop not honoured");

  property p_clkrun;
    $rose(clkrun_oe_out) |-> $past(clkrun_n_in) ##1 clkrun_oe_out ##1 !clkrun_oe_out;
  endproperty
  a_clkrun: assert property (p_clkrun) else $error("clock request wrong");

  property p_serr;
    serr_oe_out |-> $past(core_reg.chk_serr) && $past(par_if.par_err);
  endproperty
  a_serr: assert property (p_serr) else $error("system error without cause");

  property p_card_cfg;
    (core_reg.st == ST_IDLE && !frame_n_in && core_reg.frame_q && mode_card_out && cbe_in[3:1] == 3'h5)
      |=> core_reg.st != ST_TDATA;
  endproperty
  a_card_cfg: assert property (p_card_cfg) else $error("configuration claimed in card mode");
endmodule
`default_nettype wire
